/* hw/ufpc_pkg.sv */
// Constants and carrier types for the USB function power control block.
// Assumes an 8-bit special-function register port from the processor core.
//
// Operation
// RULE1: Power-down bit enters power-down mode; set only while suspend flag set.
// RULE2: Power-down bit clears on any interrupt or any reset.
// RULE3: Power-down bit is best written together with processor idle bits.
// RULE4: Without remote-wake enable no remote resume starts, firmware or external.
// RULE5: Remote-wake enable stays clear until host enables remote wake-up.
// RULE6: Wake event sets wake flag and drives wake output high.
// RULE7: Wake flag not set while wake disabled, resume flag or drive bit set.
// RULE8: Suspend/resume interrupt request is OR of wake, suspend, resume, reset.
// RULE9: Firmware handles the resume flag before wake or suspend flags.
// RULE10: Isolate bit clear: bus reset resets whole chip.
// RULE11: Isolate bit set: bus reset resets USB only and sets reset flag.
// RULE12: Isolate bit set: bus reset keeps the three interrupt enables.
// RULE13: Bus-reset flag sets on completed bus reset regardless of enable.
// RULE14: Drive bit sends K upstream and self-clears when wake-up completes.
// RULE15: Drive bit set only while suspended and not resuming.
// RULE16: Resume flag sets at start and end of upstream resume.
// RULE17: Resume flag not set while drive bit is one.
// RULE18: Suspend flag sets on suspend, clears on function resume.
// RULE19: Suspend handler sets power-down bit to really enter suspend.
// RULE20: System reset clears register; bus reset leaves only reset flag set (code also keeps the isolate bit).
// RULE21: Interrupt reaches processor only with its enable and global enable.
package ufpc_pkg;

  // ----------------------------------------------------------------
  // Register addresses and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'he7;
  localparam logic [7:0] ADDR_INT_ENABLE = 8'hb1;
  localparam logic [7:0] POWER_CONTROL_RST = 8'h00;
  localparam logic [7:0] POWER_CONTROL_BUS_RST = 8'h08;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int BIT_POWER_DOWN = 7;
  localparam int BIT_WAKE_ENABLE = 6;
  localparam int BIT_WAKE_EVENT = 5;
  localparam int BIT_RESET_ISOLATE = 4;
  localparam int BIT_BUS_RESET = 3;
  localparam int BIT_WAKE_DRIVE = 2;
  localparam int BIT_RESUME = 1;
  localparam int BIT_SUSPEND = 0;
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_SUSRES_EN = 3;
  localparam int BIT_ENDPOINT_EN = 1;

  // ----------------------------------------------------------------
  // Timing: K state length for remote wake-up, 1 ms minimum
  // ----------------------------------------------------------------
  localparam int CLOCK_HZ = 40000000;
  localparam int WAKE_K_US = 1000;
  localparam int WAKE_K_CYCLES = (CLOCK_HZ / 1000000) * WAKE_K_US;

  // Register read and write strobe carrier.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ufpc_sfr_type;

  // Events from the serial interface engine.
  typedef struct packed {
    logic suspendDetect;
    logic resumeStart;
    logic resumeEnd;
    logic busResetDone;
    logic busResetActive;
    logic wakeInput;
  } ufpc_event_type;

  typedef enum logic [1:0] {
    UFPC_IDLE = 2'b00,
    UFPC_DRIVE_K = 2'b01,
    UFPC_DONE = 2'b10
  } ufpc_wake_type;

endpackage

/* hw/ufpc_power_control.sv */
// USB function power control: suspend, resume, remote wake-up, bus reset.
// Assumes a synchronous SFR port, one-cycle event pulses and a held bus-reset active level from the SIE.
module ufpc_power_control #(
  parameter int WAKE_CYCLES = ufpc_pkg::WAKE_K_CYCLES
) (
  input wire logic clock,
  input wire logic resetn,
  input wire ufpc_pkg::ufpc_sfr_type sfr,
  input wire ufpc_pkg::ufpc_event_type evt,
  input wire logic otherIrq,
  output logic [7:0] rdata,
  output logic powerDown,
  output logic wakeOut,
  output logic driveK,
  output logic susResIrq,
  output logic chipReset,
  output logic usbReset
);

  logic [7:0] ctrl_r;
  logic [7:0] ien_r;
  logic [31:0] wakeCount_r;
  ufpc_pkg::ufpc_wake_type wakeState_r;
  logic wrCtrl;
  logic wrIen;
  logic isolate;
  logic wakeGo;
  logic wakeDone;
  logic irqAny;
  logic wakeSet;
  logic resumeSet;
  logic pdClear;
  logic [7:0] keepIsolate;

  assign wrCtrl = sfr.wr && (sfr.addr == ufpc_pkg::ADDR_POWER_CONTROL);
  assign wrIen = sfr.wr && (sfr.addr == ufpc_pkg::ADDR_INT_ENABLE);
  assign isolate = ctrl_r[ufpc_pkg::BIT_RESET_ISOLATE];
  assign wakeDone = (wakeState_r == ufpc_pkg::UFPC_DONE);
  // The firmware drive bit starts K only while remote wake is enabled.
  assign wakeGo = ctrl_r[ufpc_pkg::BIT_WAKE_ENABLE] &&
    ctrl_r[ufpc_pkg::BIT_WAKE_DRIVE]; // RULE4
  assign irqAny = ctrl_r[ufpc_pkg::BIT_WAKE_EVENT] |
    ctrl_r[ufpc_pkg::BIT_SUSPEND] | ctrl_r[ufpc_pkg::BIT_RESUME] |
    ctrl_r[ufpc_pkg::BIT_BUS_RESET]; // RULE8
  assign wakeSet = evt.wakeInput && ctrl_r[ufpc_pkg::BIT_WAKE_ENABLE] &&
    !ctrl_r[ufpc_pkg::BIT_RESUME] &&
    !ctrl_r[ufpc_pkg::BIT_WAKE_DRIVE]; // RULE7
  assign resumeSet = (evt.resumeStart || evt.resumeEnd) &&
    !ctrl_r[ufpc_pkg::BIT_WAKE_DRIVE]; // RULE17
  // Only a new interrupt event ends power-down, not a pending flag.
  assign pdClear = wakeSet || resumeSet || evt.suspendDetect || otherIrq;
  // The isolate bit survives a bus reset so the enables stay protected.
  assign keepIsolate = ctrl_r & (8'h01 << ufpc_pkg::BIT_RESET_ISOLATE);

  // ----------------------------------------------------------------
  // Power control register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ctrl_r <= ufpc_pkg::POWER_CONTROL_RST; // RULE20
    end else if (evt.busResetActive) begin
      ctrl_r <= ufpc_pkg::POWER_CONTROL_RST | keepIsolate; // RULE2
    end else if (evt.busResetDone) begin
      ctrl_r <= ufpc_pkg::POWER_CONTROL_BUS_RST | keepIsolate; // RULE13 RULE20
    end else begin
      if (wrCtrl) begin
        ctrl_r[ufpc_pkg::BIT_WAKE_ENABLE] <=
          sfr.wdata[ufpc_pkg::BIT_WAKE_ENABLE]; // RULE5
        ctrl_r[ufpc_pkg::BIT_RESET_ISOLATE] <=
          sfr.wdata[ufpc_pkg::BIT_RESET_ISOLATE];
        ctrl_r[ufpc_pkg::BIT_WAKE_EVENT] <=
          sfr.wdata[ufpc_pkg::BIT_WAKE_EVENT];
        ctrl_r[ufpc_pkg::BIT_BUS_RESET] <= sfr.wdata[ufpc_pkg::BIT_BUS_RESET];
        ctrl_r[ufpc_pkg::BIT_RESUME] <= sfr.wdata[ufpc_pkg::BIT_RESUME];
        ctrl_r[ufpc_pkg::BIT_SUSPEND] <= sfr.wdata[ufpc_pkg::BIT_SUSPEND];
        // Power-down is taken only while suspended.
        ctrl_r[ufpc_pkg::BIT_POWER_DOWN] <=
          sfr.wdata[ufpc_pkg::BIT_POWER_DOWN] &&
          ctrl_r[ufpc_pkg::BIT_SUSPEND]; // RULE1 RULE3 RULE19
        ctrl_r[ufpc_pkg::BIT_WAKE_DRIVE] <=
          sfr.wdata[ufpc_pkg::BIT_WAKE_DRIVE] &&
          ctrl_r[ufpc_pkg::BIT_SUSPEND] &&
          !ctrl_r[ufpc_pkg::BIT_RESUME]; // RULE15
      end
      if (pdClear) begin
        ctrl_r[ufpc_pkg::BIT_POWER_DOWN] <= 1'b0; // RULE2
      end
      if (wakeDone) begin
        ctrl_r[ufpc_pkg::BIT_WAKE_DRIVE] <= 1'b0; // RULE14
      end
      if (wakeSet) begin
        ctrl_r[ufpc_pkg::BIT_WAKE_EVENT] <= 1'b1; // RULE6 RULE7
      end
      if (resumeSet) begin
        ctrl_r[ufpc_pkg::BIT_RESUME] <= 1'b1; // RULE16 RULE17 RULE9
      end
      if (evt.resumeEnd || wakeDone) begin
        ctrl_r[ufpc_pkg::BIT_SUSPEND] <= 1'b0; // RULE18
      end
      if (evt.suspendDetect) begin
        ctrl_r[ufpc_pkg::BIT_SUSPEND] <= 1'b1; // RULE18
      end
    end
  end

  // ----------------------------------------------------------------
  // Interrupt enable register
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      ien_r <= 8'h00;
    end else if (evt.busResetActive && !isolate) begin
      ien_r <= 8'h00; // RULE10
    end else if (wrIen) begin
      ien_r <= sfr.wdata & 8'h8a; // RULE12
    end
  end

  // ----------------------------------------------------------------
  // Remote wake-up K state sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      wakeState_r <= ufpc_pkg::UFPC_IDLE;
      wakeCount_r <= 32'h0;
    end else begin
      case (wakeState_r)
        ufpc_pkg::UFPC_IDLE: begin
          wakeCount_r <= 32'h0;
          if (wakeGo && !evt.busResetActive) begin
            wakeState_r <= ufpc_pkg::UFPC_DRIVE_K; // RULE4
          end
        end
        ufpc_pkg::UFPC_DRIVE_K: begin
          wakeCount_r <= wakeCount_r + 32'h1;
          if (evt.busResetActive) begin
            wakeState_r <= ufpc_pkg::UFPC_IDLE;
          end else if (wakeCount_r >= 32'(WAKE_CYCLES - 1)) begin
            wakeState_r <= ufpc_pkg::UFPC_DONE; // RULE14
          end
        end
        ufpc_pkg::UFPC_DONE: begin
          wakeState_r <= ufpc_pkg::UFPC_IDLE;
        end
        default: begin
          wakeState_r <= ufpc_pkg::UFPC_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clock or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
      powerDown <= 1'b0;
      wakeOut <= 1'b0;
      driveK <= 1'b0;
      susResIrq <= 1'b0;
      chipReset <= 1'b0;
      usbReset <= 1'b0;
    end else begin
      if (sfr.rd && sfr.addr == ufpc_pkg::ADDR_POWER_CONTROL) begin
        rdata <= ctrl_r;
      end else if (sfr.rd && sfr.addr == ufpc_pkg::ADDR_INT_ENABLE) begin
        rdata <= ien_r;
      end else begin
        rdata <= 8'h00;
      end
      powerDown <= ctrl_r[ufpc_pkg::BIT_POWER_DOWN]; // RULE1
      wakeOut <= ctrl_r[ufpc_pkg::BIT_WAKE_EVENT]; // RULE6
      driveK <= (wakeState_r == ufpc_pkg::UFPC_DRIVE_K); // RULE14
      susResIrq <= irqAny && ien_r[ufpc_pkg::BIT_SUSRES_EN] &&
        ien_r[ufpc_pkg::BIT_GLOBAL_EN]; // RULE21
      chipReset <= evt.busResetActive && !isolate; // RULE10
      usbReset <= evt.busResetActive; // RULE11
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_wake_gate;
    @(posedge clock) disable iff (!resetn)
    !ctrl_r[ufpc_pkg::BIT_WAKE_ENABLE] && !evt.busResetActive &&
      !evt.busResetDone && !wrCtrl |=> !$rose(ctrl_r[ufpc_pkg::BIT_WAKE_EVENT]);
  endproperty
  a_wake_gate: assert property (p_wake_gate) else $error("wake set off"); // RULE7

  property p_no_k_disabled;
    @(posedge clock) disable iff (!resetn)
    wakeState_r == ufpc_pkg::UFPC_IDLE && !ctrl_r[ufpc_pkg::BIT_WAKE_ENABLE]
      |=> wakeState_r == ufpc_pkg::UFPC_IDLE;
  endproperty
  a_no_k_disabled: assert property (p_no_k_disabled)
    else $error("K started while disabled"); // RULE4

  property p_irq;
    @(posedge clock) disable iff (!resetn)
    irqAny && ien_r[3] && ien_r[7] |=> susResIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing"); // RULE21

  property p_irq_gate;
    @(posedge clock) disable iff (!resetn)
    !ien_r[ufpc_pkg::BIT_GLOBAL_EN] |=> !susResIrq;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("irq ungated"); // RULE21

  property p_bus_reset;
    @(posedge clock) disable iff (!resetn)
    evt.busResetDone && !evt.busResetActive |=>
      ctrl_r == (ufpc_pkg::POWER_CONTROL_BUS_RST | $past(keepIsolate));
  endproperty
  a_bus_reset: assert property (p_bus_reset)
    else $error("bus reset value"); // RULE20

  property p_isolate;
    @(posedge clock) disable iff (!resetn)
    evt.busResetActive && isolate && !wrIen |=> $stable(ien_r);
  endproperty
  a_isolate: assert property (p_isolate) else $error("enables lost"); // RULE12

  property p_chip_reset;
    @(posedge clock) disable iff (!resetn)
    evt.busResetActive |=> chipReset == !$past(isolate);
  endproperty
  a_chip_reset: assert property (p_chip_reset)
    else $error("chip reset wrong"); // RULE10

  property p_pd_clear;
    @(posedge clock) disable iff (!resetn)
    pdClear |=> !ctrl_r[ufpc_pkg::BIT_POWER_DOWN];
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("pd kept"); // RULE2

  sequence s_drive_end;
    wakeState_r == ufpc_pkg::UFPC_DONE;
  endsequence
  property p_drive_clear;
    @(posedge clock) disable iff (!resetn)
    s_drive_end ##0 (!evt.busResetDone && !evt.busResetActive)
      |=> !ctrl_r[ufpc_pkg::BIT_WAKE_DRIVE];
  endproperty
  a_drive_clear: assert property (p_drive_clear)
    else $error("drive bit kept"); // RULE14

  property p_resume_block;
    @(posedge clock) disable iff (!resetn)
    ctrl_r[ufpc_pkg::BIT_WAKE_DRIVE] && !ctrl_r[ufpc_pkg::BIT_RESUME] &&
      !wrCtrl && !evt.busResetDone |=> !ctrl_r[ufpc_pkg::BIT_RESUME];
  endproperty
  a_resume_block: assert property (p_resume_block)
    else $error("resume set in wake"); // RULE17

  property p_pd_gate;
    @(posedge clock) disable iff (!resetn)
    wrCtrl && !ctrl_r[ufpc_pkg::BIT_SUSPEND] && !evt.busResetActive &&
      !evt.busResetDone |=> !ctrl_r[ufpc_pkg::BIT_POWER_DOWN];
  endproperty
  a_pd_gate: assert property (p_pd_gate) // RULE1
    else $error("pd not gated");

  property p_pd_out;
    @(posedge clock) disable iff (!resetn)
    ctrl_r[ufpc_pkg::BIT_POWER_DOWN] |=> powerDown;
  endproperty
  a_pd_out: assert property (p_pd_out) // RULE1
    else $error("pd output missing");

  sequence s_wake_event;
    wakeSet && !evt.busResetActive && !evt.busResetDone;
  endsequence
  sequence s_wake_shown;
    ctrl_r[ufpc_pkg::BIT_WAKE_EVENT] ##1 wakeOut;
  endsequence
  property p_wake_set;
    @(posedge clock) disable iff (!resetn)
    s_wake_event |=> s_wake_shown;
  endproperty
  a_wake_set: assert property (p_wake_set) // RULE6
    else $error("wake event lost");

  property p_resume_set;
    @(posedge clock) disable iff (!resetn)
    resumeSet && !evt.busResetActive && !evt.busResetDone
      |=> ctrl_r[ufpc_pkg::BIT_RESUME];
  endproperty
  a_resume_set: assert property (p_resume_set) // RULE16
    else $error("resume flag lost");

  property p_suspend_set;
    @(posedge clock) disable iff (!resetn)
    evt.suspendDetect && !evt.busResetActive && !evt.busResetDone
      |=> ctrl_r[ufpc_pkg::BIT_SUSPEND];
  endproperty
  a_suspend_set: assert property (p_suspend_set) // RULE18
    else $error("suspend flag lost");

  property p_suspend_clear;
    @(posedge clock) disable iff (!resetn)
    (evt.resumeEnd || wakeDone) && !evt.suspendDetect && !evt.busResetActive &&
      !evt.busResetDone |=> !ctrl_r[ufpc_pkg::BIT_SUSPEND];
  endproperty
  a_suspend_clear: assert property (p_suspend_clear) // RULE18
    else $error("suspend flag kept");

  property p_irq_idle;
    @(posedge clock) disable iff (!resetn)
    !irqAny |=> !susResIrq;
  endproperty
  a_irq_idle: assert property (p_irq_idle) // RULE8
    else $error("irq without flag");

  property p_drive_refuse;
    @(posedge clock) disable iff (!resetn)
    wrCtrl && (!ctrl_r[ufpc_pkg::BIT_SUSPEND] || ctrl_r[ufpc_pkg::BIT_RESUME]) &&
      !ctrl_r[ufpc_pkg::BIT_WAKE_DRIVE] && !evt.busResetActive &&
      !evt.busResetDone |=> !ctrl_r[ufpc_pkg::BIT_WAKE_DRIVE];
  endproperty
  a_drive_refuse: assert property (p_drive_refuse) // RULE15
    else $error("drive bit taken");

  sequence s_k_on;
    wakeState_r == ufpc_pkg::UFPC_DRIVE_K ##1 driveK;
  endsequence
  property p_k_start;
    @(posedge clock) disable iff (!resetn)
    wakeState_r == ufpc_pkg::UFPC_IDLE && wakeGo && !evt.busResetActive
      |=> s_k_on;
  endproperty
  a_k_start: assert property (p_k_start) // RULE14
    else $error("K not started");

  property p_k_hold;
    @(posedge clock) disable iff (!resetn)
    wakeState_r == ufpc_pkg::UFPC_DRIVE_K &&
      wakeCount_r < 32'(WAKE_CYCLES - 1) && !evt.busResetActive
      |=> wakeState_r == ufpc_pkg::UFPC_DRIVE_K;
  endproperty
  a_k_hold: assert property (p_k_hold) // RULE14
    else $error("K ended early");

  property p_usb_reset;
    @(posedge clock) disable iff (!resetn)
    evt.busResetActive |=> usbReset;
  endproperty
  a_usb_reset: assert property (p_usb_reset) // RULE11
    else $error("usb reset missing");

  property p_reset_quiet;
    @(posedge clock) disable iff (!resetn)
    !evt.busResetActive |=> !usbReset && !chipReset;
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) // RULE10
    else $error("reset without bus reset");

endmodule

/* verif/ufpc_host_model.sv */
// Upstream host and bus-engine events seen by the power control block.
// Assumes the bench calls its tasks; events change only after a clock edge.
module ufpc_host_model (
  input wire logic clock,
  output ufpc_pkg::ufpc_event_type evt
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    evt = '0;
  end

  // ------------------------------------------------------------
  // Event drivers
  // ------------------------------------------------------------
  // Bits: 5 suspend, 4 resume start, 3 resume end, 2 reset done,
  // 1 reset active, 0 external wake input.
  task automatic pulse(input int b);
    @(posedge clock);
    evt[b] <= 1'b1;
    @(posedge clock);
    evt[b] <= 1'b0;
  endtask

  // Bus reset signalling holds the active level, then reports completion.
  task automatic reset_start();
    @(posedge clock);
    evt.busResetActive <= 1'b1;
  endtask

  task automatic reset_end();
    @(posedge clock);
    evt.busResetActive <= 1'b0;
    evt.busResetDone <= 1'b1;
    @(posedge clock);
    evt.busResetDone <= 1'b0;
  endtask
endmodule

/* verif/test_usb_function_power_control.sv */
// Self-checking bench for the USB function power control block.
// Assumes the host model drives events and the bench owns the SFR port.
module test_usb_function_power_control;
  timeunit 1ns;
  timeprecision 1ps;

  logic clock;
  logic resetn;
  ufpc_pkg::ufpc_sfr_type sfr;
  ufpc_pkg::ufpc_event_type evt;
  logic otherIrq;
  logic [7:0] rdata;
  logic powerDown, wakeOut, driveK, susResIrq, chipReset, usbReset;
  int badCount = 0;
  int comparisons = 0;

  ufpc_power_control #(.WAKE_CYCLES(8)) ufpc_power_control_inst (
    .clock(clock),
    .resetn(resetn),
    .sfr(sfr),
    .evt(evt),
    .otherIrq(otherIrq),
    .rdata(rdata),
    .powerDown(powerDown),
    .wakeOut(wakeOut),
    .driveK(driveK),
    .susResIrq(susResIrq),
    .chipReset(chipReset),
    .usbReset(usbReset)
  );

  ufpc_host_model ufpc_host_model_inst (
    .clock(clock),
    .evt(evt)
  );

  initial begin
    clock = 1'b0;
    forever #12.5 clock = ~clock;
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      badCount++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    sfr <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock);
    sfr.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clock);
    sfr <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clock);
    sfr.rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic complete_run();
    $display("comparisons=%0d errors=%0d", comparisons, badCount);
    if (badCount == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_reset_and_refusals();
    rd(8'he7, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'he7, 8'h80);
    settle(3);
    check(powerDown, 1'b0);
    wr(8'he7, 8'h00);
    ufpc_host_model_inst.pulse(0);
    settle(3);
    check(wakeOut, 1'b0);
  endtask

  task automatic t_wake_event();
    wr(8'he7, 8'h40);
    ufpc_host_model_inst.pulse(0);
    settle(3);
    check(wakeOut, 1'b1);
    rd(8'he7, 8'h60);
    wr(8'he7, 8'h00);
  endtask

  task automatic t_suspend_irq();
    wr(8'hb1, 8'h08);
    ufpc_host_model_inst.pulse(5);
    rd(8'he7, 8'h01);
    settle(2);
    check(susResIrq, 1'b0);
    wr(8'hb1, 8'h88);
    settle(3);
    check(susResIrq, 1'b1);
  endtask

  task automatic t_power_down();
    wr(8'he7, 8'h81);
    settle(2);
    check(powerDown, 1'b1);
    rd(8'he7, 8'h81);
    @(posedge clock);
    otherIrq <= 1'b1;
    @(posedge clock);
    otherIrq <= 1'b0;
    settle(2);
    check(powerDown, 1'b0);
    rd(8'he7, 8'h01);
  endtask

  task automatic t_system_reset();
    wr(8'he7, 8'h50);
    @(posedge clock);
    resetn <= 1'b0;
    repeat (2) @(posedge clock);
    resetn <= 1'b1;
    rd(8'he7, 8'h00);
  endtask

  task automatic t_remote_wake();
    wr(8'he7, 8'h05);
    settle(5);
    check(driveK, 1'b0);
    wr(8'he7, 8'h45);
    settle(4);
    check(driveK, 1'b1);
    settle(12);
    check(driveK, 1'b0);
    rd(8'he7, 8'h40);
  endtask

  task automatic t_resume();
    ufpc_host_model_inst.pulse(4);
    rd(8'he7, 8'h42);
    ufpc_host_model_inst.pulse(5);
    rd(8'he7, 8'h43);
    wr(8'he7, 8'h47);
    rd(8'he7, 8'h43);
    ufpc_host_model_inst.pulse(3);
    rd(8'he7, 8'h42);
    wr(8'he7, 8'h00);
  endtask

  task automatic t_bus_reset(input logic iso);
    wr(8'he7, {3'b000, iso, 4'h0});
    wr(8'hb1, 8'h8a);
    ufpc_host_model_inst.reset_start();
    settle(3);
    check(usbReset, 1'b1);
    check(chipReset, !iso);
    ufpc_host_model_inst.reset_end();
    settle(2);
    rd(8'he7, {3'b000, iso, 4'h8});
    rd(8'hb1, iso ? 8'h8a : 8'h00);
  endtask

  initial begin
    resetn = 1'b0;
    sfr = '0;
    otherIrq = 1'b0;
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    t_reset_and_refusals();
    t_wake_event();
    t_suspend_irq();
    t_power_down();
    t_remote_wake();
    t_resume();
    t_system_reset();
    t_bus_reset(1'b1);
    t_bus_reset(1'b0);
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge clock);
    badCount++;
    complete_run();
  end
endmodule
